/* File: verilog/sod_regs.svh */
// register indices, field positions, command codes and reset values
`ifndef SOD_REGS_SVH
`define SOD_REGS_SVH
`define SOD_IDX_SLICE1     8'h0c
`define SOD_IDX_SLICE2     8'h0d
`define SOD_IDX_SLICE3     8'h0e
`define SOD_TAP_W          9
`define SOD_TAP_MSB        8
`define SOD_TAP_RESET      9'h000
`define SOD_BIT_COARSE     13
`define SOD_BIT_DOWN       14
`define SOD_BIT_UP         15
`define SOD_CMD_STEP_UP    3'h1
`define SOD_CMD_STEP_DOWN  3'h2
`define SOD_CMD_COARSE_UP  3'h5
`define SOD_CMD_COARSE_DN  3'h6
`define SOD_ONE_TAP        9'h001
`define SOD_HTRANS_NONSEQ  2'h2
`define SOD_HTRANS_SEQ     2'h3
`endif

/* File: verilog/sod_pkg.sv */
// types shared by the slice output delay register bank
package sod_pkg;
   typedef logic [8:0] sod_tap_type;
   typedef logic [2:0] sod_cmd_type;
endpackage

/* File: verilog/sod_tap_if.sv */
// carrier between the register bank and the tap update unit
`timescale 1ns/1ns
interface sod_tap_if;
   import sod_pkg::*;
   logic        load;
   sod_cmd_type cmd;
   sod_tap_type wdata;
   sod_tap_type cur;
   sod_tap_type step;
   sod_tap_type result;
   modport bank (output load, cmd, wdata, cur, step, input result);
   modport unit (input load, cmd, wdata, cur, step, output result);
endinterface

/* File: verilog/sod_tap_unit.sv */
// computes the new tap value for one write command
`timescale 1ns/1ns
`include "sod_regs.svh"
module sod_tap_unit
(
   sod_tap_if.unit t
);
   import sod_pkg::*;

   // 9-bit arithmetic gives the modulo 512 wrap for free
   function automatic sod_tap_type apply_cmd(input sod_cmd_type c,
                                             input sod_tap_type cur,
                                             input sod_tap_type wd,
                                             input sod_tap_type stp);
      case (c)
         `SOD_CMD_STEP_UP:   apply_cmd = cur + `SOD_ONE_TAP;
         `SOD_CMD_STEP_DOWN: apply_cmd = cur - `SOD_ONE_TAP;
         `SOD_CMD_COARSE_UP: apply_cmd = cur + stp;
         `SOD_CMD_COARSE_DN: apply_cmd = cur - stp;
         default:            apply_cmd = wd;
      endcase
   endfunction

   always_comb
   begin
      t.result = apply_cmd(t.cmd, t.cur, t.wdata, t.step);
   end
endmodule // sod_tap_unit

/* File: verilog/sod_bank.sv */
// ahb-lite register bank for slice 1..3 output delay taps
`timescale 1ns/1ns
`include "sod_regs.svh"
module sod_bank
#(
   parameter int TAP_W = `SOD_TAP_W
)
(
   input  wire logic                hclk,
   input  wire logic                hresetn,
   input  wire logic                hsel,
   input  wire logic [31:0]         haddr,
   input  wire logic [1:0]          htrans,
   input  wire logic                hwrite,
   input  wire logic [2:0]          hsize,
   input  wire logic [31:0]         hwdata,
   input  wire logic                hready,
   output logic      [31:0]         hrdata,
   output logic                     hreadyout,
   output logic                     hresp,
   input  wire logic [8:0]          coarse_step,
   input  wire logic                fabric_load,
   input  wire logic [35:0]         fabric_tap_load_bus,
   output logic      [35:0]         fabric_tap_readback_bus
);
   import sod_pkg::*;

   sod_tap_type slice1_tap_value_reg, slice1_tap_value_next;
   sod_tap_type slice2_tap_value_reg, slice2_tap_value_next;
   sod_tap_type slice3_tap_value_reg, slice3_tap_value_next;
   logic        wr_pend_reg, wr_pend_next;
   logic [1:0]  wr_sel_reg, wr_sel_next;
   logic [31:0] hrdata_reg, hrdata_next;
   logic [1:0]  sel_now;
   logic        fab_ld_s1, fab_ld_s2;
   logic [35:0] fab_bus_s1, fab_bus_s2;
   logic        addr_ok;
   sod_tap_type cur_sel;

   sod_tap_if tap();

   sod_tap_unit u_unit
   (
      .t (tap.unit)
   );

   // register index n lives at byte address 4*n
   function automatic logic [1:0] decode(input logic [31:0] a);
      if (a[1:0] != 2'h0 || a[31:10] != 22'h0)
         decode = 2'h0;
      else if (a[9:2] == `SOD_IDX_SLICE1)
         decode = 2'h1;
      else if (a[9:2] == `SOD_IDX_SLICE2)
         decode = 2'h2;
      else if (a[9:2] == `SOD_IDX_SLICE3)
         decode = 2'h3;
      else
         decode = 2'h0;
   endfunction

   function automatic sod_tap_type pick(input logic [1:0] s,
                                        input sod_tap_type a,
                                        input sod_tap_type b,
                                        input sod_tap_type c);
      case (s)
         2'h1:    pick = a;
         2'h2:    pick = b;
         2'h3:    pick = c;
         default: pick = '0;
      endcase
   endfunction

   // fabric load pins come from another domain: two stages first
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         fab_ld_s1  <= 1'b0;
         fab_ld_s2  <= 1'b0;
         fab_bus_s1 <= 36'h0;
         fab_bus_s2 <= 36'h0;
      end
      else
      begin
         fab_ld_s1  <= fabric_load;
         fab_ld_s2  <= fab_ld_s1;
         fab_bus_s1 <= fabric_tap_load_bus;
         fab_bus_s2 <= fab_bus_s1;
      end
   end

   assign addr_ok = hsel && hready &&
                    (htrans == `SOD_HTRANS_NONSEQ ||
                     htrans == `SOD_HTRANS_SEQ);
   assign sel_now = decode(haddr);
   assign cur_sel = pick(wr_sel_reg, slice1_tap_value_reg,
                         slice2_tap_value_reg, slice3_tap_value_reg);

   always_comb
   begin
      tap.load  = wr_pend_reg;
      tap.cmd   = {hwdata[`SOD_BIT_COARSE], hwdata[`SOD_BIT_DOWN],
                   hwdata[`SOD_BIT_UP]};
      tap.wdata = hwdata[`SOD_TAP_MSB:0];
      tap.cur   = cur_sel;
      tap.step  = coarse_step;
   end

   always_comb
   begin
      wr_pend_next = addr_ok && hwrite && sel_now != 2'h0;
      wr_sel_next  = sel_now;
      hrdata_next  = hrdata_reg;
      slice1_tap_value_next = slice1_tap_value_reg;
      slice2_tap_value_next = slice2_tap_value_reg;
      slice3_tap_value_next = slice3_tap_value_reg;
      // fabric load has the same effect as a direct register load; a bus
      // write in the same cycle wins since it is the later software intent
      if (fab_ld_s2)
      begin
         slice1_tap_value_next = fab_bus_s2[17:9];
         slice2_tap_value_next = fab_bus_s2[26:18];
         slice3_tap_value_next = fab_bus_s2[35:27];
      end
      if (wr_pend_reg)
      begin
         case (wr_sel_reg)
            2'h1:    slice1_tap_value_next = tap.result;
            2'h2:    slice2_tap_value_next = tap.result;
            2'h3:    slice3_tap_value_next = tap.result;
            default: ;
         endcase
      end
      // read data is prepared in the address phase; command bits read 0
      if (addr_ok && !hwrite)
         hrdata_next = {{(32-TAP_W){1'b0}}, pick(sel_now,
                        slice1_tap_value_reg,
                        slice2_tap_value_reg, slice3_tap_value_reg)};
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         slice1_tap_value_reg <= `SOD_TAP_RESET;
         slice2_tap_value_reg <= `SOD_TAP_RESET;
         slice3_tap_value_reg <= `SOD_TAP_RESET;
         wr_pend_reg          <= 1'b0;
         wr_sel_reg           <= 2'h0;
         hrdata_reg           <= 32'h0;
      end
      else
      begin
         slice1_tap_value_reg <= slice1_tap_value_next;
         slice2_tap_value_reg <= slice2_tap_value_next;
         slice3_tap_value_reg <= slice3_tap_value_next;
         wr_pend_reg          <= wr_pend_next;
         wr_sel_reg           <= wr_sel_next;
         hrdata_reg           <= hrdata_next;
      end
   end

   // zero wait states, always OKAY; the slice 0 segment is not ours
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_reg;
   assign fabric_tap_readback_bus = {slice3_tap_value_reg,
                                     slice2_tap_value_reg,
                                     slice1_tap_value_reg,
                                     9'h000};

   property p_step_up;
      @(posedge hclk) disable iff (!hresetn)
      (wr_pend_reg && wr_sel_reg == 2'h1 && !fab_ld_s2 &&
       tap.cmd == `SOD_CMD_STEP_UP)
      |=> slice1_tap_value_reg == $past(slice1_tap_value_reg) + 9'h001;
   endproperty
   a_step_up: assert property (p_step_up)
      else $error("slice1 step up wrong");

   property p_step_down;
      @(posedge hclk) disable iff (!hresetn)
      (wr_pend_reg && wr_sel_reg == 2'h2 && !fab_ld_s2 &&
       tap.cmd == `SOD_CMD_STEP_DOWN)
      |=> slice2_tap_value_reg == $past(slice2_tap_value_reg) - 9'h001;
   endproperty
   a_step_down: assert property (p_step_down)
      else $error("slice2 step down wrong");

   property p_coarse_up;
      @(posedge hclk) disable iff (!hresetn)
      (wr_pend_reg && wr_sel_reg == 2'h3 && tap.cmd == `SOD_CMD_COARSE_UP)
      |=> slice3_tap_value_reg ==
          sod_tap_type'($past(slice3_tap_value_reg) + $past(coarse_step));
   endproperty
   a_coarse_up: assert property (p_coarse_up)
      else $error("coarse up wrong");

   property p_coarse_dn;
      @(posedge hclk) disable iff (!hresetn)
      (wr_pend_reg && wr_sel_reg == 2'h1 && tap.cmd == `SOD_CMD_COARSE_DN)
      |=> slice1_tap_value_reg ==
          sod_tap_type'($past(slice1_tap_value_reg) - $past(coarse_step));
   endproperty
   a_coarse_dn: assert property (p_coarse_dn)
      else $error("coarse down wrong");

   sequence s_load_write;
      wr_pend_reg && wr_sel_reg == 2'h2 &&
      (tap.cmd == 3'h0 || tap.cmd == 3'h3 ||
       tap.cmd == 3'h4 || tap.cmd == 3'h7);
   endsequence
   property p_load;
      @(posedge hclk) disable iff (!hresetn)
      s_load_write |=> slice2_tap_value_reg == $past(hwdata[8:0]);
   endproperty
   a_load: assert property (p_load)
      else $error("direct load wrong");

   property p_readback;
      @(posedge hclk) disable iff (!hresetn)
      (addr_ok && !hwrite && sel_now == 2'h3)
      |=> hrdata == {23'h0, $past(fabric_tap_readback_bus[35:27])};
   endproperty
   a_readback: assert property (p_readback)
      else $error("slice3 readback mismatch");

   property p_cmd_zero;
      @(posedge hclk) disable iff (!hresetn)
      hrdata[31:9] == 23'h0;
   endproperty
   a_cmd_zero: assert property (p_cmd_zero)
      else $error("command bits read nonzero");

   property p_fabric;
      @(posedge hclk) disable iff (!hresetn)
      (fab_ld_s2 && !wr_pend_reg)
      |=> fabric_tap_readback_bus[26:18] == $past(fab_bus_s2[26:18]);
   endproperty
   a_fabric: assert property (p_fabric)
      else $error("fabric load mismatch");

   property p_seg;
      @(posedge hclk) disable iff (!hresetn)
      (addr_ok && !hwrite && sel_now == 2'h1 && !wr_pend_reg)
      |=> hrdata[8:0] == $past(fabric_tap_readback_bus[17:9]);
   endproperty
   a_seg: assert property (p_seg)
      else $error("slice1 readback mismatch");

   property p_readback2;
      @(posedge hclk) disable iff (!hresetn)
      (addr_ok && !hwrite && sel_now == 2'h2)
      |=> hrdata == {23'h0, $past(fabric_tap_readback_bus[26:18])};
   endproperty
   a_readback2: assert property (p_readback2)
      else $error("slice2 readback mismatch");

   property p_up_s3;
      @(posedge hclk) disable iff (!hresetn)
      (wr_pend_reg && wr_sel_reg == 2'h3 && tap.cmd == `SOD_CMD_STEP_UP)
      |=> slice3_tap_value_reg == $past(slice3_tap_value_reg) + 9'h001;
   endproperty
   a_up_s3: assert property (p_up_s3)
      else $error("slice3 step up wrong");

   property p_dn_s1;
      @(posedge hclk) disable iff (!hresetn)
      (wr_pend_reg && wr_sel_reg == 2'h1 && tap.cmd == `SOD_CMD_STEP_DOWN)
      |=> slice1_tap_value_reg == $past(slice1_tap_value_reg) - 9'h001;
   endproperty
   a_dn_s1: assert property (p_dn_s1)
      else $error("slice1 step down wrong");

   property p_cu_s2;
      @(posedge hclk) disable iff (!hresetn)
      (wr_pend_reg && wr_sel_reg == 2'h2 && tap.cmd == `SOD_CMD_COARSE_UP)
      |=> slice2_tap_value_reg ==
          sod_tap_type'($past(slice2_tap_value_reg) + $past(coarse_step));
   endproperty
   a_cu_s2: assert property (p_cu_s2)
      else $error("slice2 coarse up wrong");

   property p_cd_s3;
      @(posedge hclk) disable iff (!hresetn)
      (wr_pend_reg && wr_sel_reg == 2'h3 && tap.cmd == `SOD_CMD_COARSE_DN)
      |=> slice3_tap_value_reg ==
          sod_tap_type'($past(slice3_tap_value_reg) - $past(coarse_step));
   endproperty
   a_cd_s3: assert property (p_cd_s3)
      else $error("slice3 coarse down wrong");

   property p_load_s1;
      @(posedge hclk) disable iff (!hresetn)
      (wr_pend_reg && wr_sel_reg == 2'h1 &&
       (tap.cmd == 3'h0 || tap.cmd == 3'h3 ||
        tap.cmd == 3'h4 || tap.cmd == 3'h7))
      |=> slice1_tap_value_reg == $past(hwdata[8:0]);
   endproperty
   a_load_s1: assert property (p_load_s1)
      else $error("slice1 direct load wrong");

   property p_load_s3;
      @(posedge hclk) disable iff (!hresetn)
      (wr_pend_reg && wr_sel_reg == 2'h3 &&
       (tap.cmd == 3'h0 || tap.cmd == 3'h3 ||
        tap.cmd == 3'h4 || tap.cmd == 3'h7))
      |=> slice3_tap_value_reg == $past(hwdata[8:0]);
   endproperty
   a_load_s3: assert property (p_load_s3)
      else $error("slice3 direct load wrong");

   // taps may only move on a write or a fabric load
   property p_hold;
      @(posedge hclk) disable iff (!hresetn)
      (!wr_pend_reg && !fab_ld_s2)
      |=> $stable(slice1_tap_value_reg) && $stable(slice2_tap_value_reg) &&
          $stable(slice3_tap_value_reg);
   endproperty
   a_hold: assert property (p_hold)
      else $error("tap changed without a write");
endmodule // sod_bank

/* File: sim/slice_output_delay_regs_tb_top.sv */
// self-checking bench for the slice output delay register bank
`timescale 1ns/1ns
`include "sod_regs.svh"
module slice_output_delay_regs_tb_top;
   import sod_pkg::*;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic        hready;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic [8:0]  coarse_step = 9'h0;
   logic        fabric_load = 1'b0;
   logic [35:0] fabric_tap_load_bus = 36'h0;
   logic [35:0] fabric_tap_readback_bus;
   int          error_cnt = 0;
   int          checked = 0;
   int          cycles = 0;
   int          seed = 32'h32bff94d;
   int          tap [3];
   // single slave, so its own ready closes the loop
   assign hready = hreadyout;
   sod_bank DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .coarse_step(coarse_step),
      .fabric_load(fabric_load), .fabric_tap_load_bus(fabric_tap_load_bus),
      .fabric_tap_readback_bus(fabric_tap_readback_bus));
   initial
   begin
      forever #25 hclk = ~hclk;
   end
   task end_of_test();
      $display("mismatches %0d comparisons %0d", error_cnt, checked);
      if (error_cnt == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   always @(posedge hclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         error_cnt++;
         end_of_test();
      end
   end
   task chk(input logic [35:0] seen, input logic [35:0] exp);
      checked++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
            output logic [31:0] r);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= `SOD_HTRANS_NONSEQ;
      haddr <= a;
      hwrite <= w;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      r = hrdata;
      chk(36'(hresp), 36'h0);
   endtask
   function automatic int model(int cur, int wd, int c, int st);
      case (c)
         1: return (cur + 1) & 511;
         2: return (cur - 1) & 511;
         5: return (cur + st) & 511;
         6: return (cur - st) & 511;
         default: return wd;
      endcase
   endfunction
   task verify();
      logic [31:0] r;
      for (int s = 0; s < 3; s++)
      begin
         ahb(1'b0, {22'h0, `SOD_IDX_SLICE1 + 8'(s), 2'b00}, 32'h0, r);
         chk(36'(r), 36'(tap[s]));
         chk(36'(fabric_tap_readback_bus[9*s+9 +: 9]), 36'(tap[s]));
      end
      chk(36'(fabric_tap_readback_bus[8:0]), 36'h0);
   endtask
   task wr(input int s, input logic [2:0] c, input logic [8:0] d);
      logic [31:0] r;
      logic [3:0]  rsv;
      rsv = 4'($random(seed));
      ahb(1'b1, {22'h0, `SOD_IDX_SLICE1 + 8'(s), 2'b00},
          {16'h0, c[0], c[1], c[2], rsv, d}, r);
      tap[s] = model(tap[s], d, c, coarse_step);
      verify();
   endtask
   initial
   begin
      logic [31:0] r;
      tap = '{0, 0, 0};
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      verify();
      for (int s = 0; s < 3; s++)
      begin
         coarse_step <= 9'h20;
         wr(s, 3'h0, 9'h1ff);
         wr(s, `SOD_CMD_STEP_UP, 9'h055);
         wr(s, `SOD_CMD_STEP_DOWN, 9'h0aa);
         wr(s, 3'h3, 9'h1f0);
         wr(s, `SOD_CMD_COARSE_UP, 9'h000);
         wr(s, `SOD_CMD_COARSE_DN, 9'h1ff);
         for (int c = 0; c < 8; c++)
            wr(s, 3'(c), 9'($random(seed)));
      end
      repeat (40)
      begin
         coarse_step <= 9'($random(seed));
         wr({$random(seed)} % 3, 3'($random(seed)), 9'($random(seed)));
      end
      // unmapped and misaligned writes must leave every tap alone
      ahb(1'b1, 32'h0000_003c, 32'h0000_0123, r);
      ahb(1'b1, 32'h0000_0031, 32'h0000_0077, r);
      ahb(1'b0, 32'h0000_003c, 32'h0, r);
      chk(36'(r), 36'h0);
      verify();
      // fabric load goes through a two stage synchroniser
      @(posedge hclk);
      fabric_tap_load_bus <= 36'({$random(seed), $random(seed)});
      fabric_load <= 1'b1;
      repeat (6) @(posedge hclk);
      fabric_load <= 1'b0;
      repeat (4) @(posedge hclk);
      for (int s = 0; s < 3; s++)
         tap[s] = fabric_tap_load_bus[9*s+9 +: 9];
      verify();
      wr(1, 3'h4, 9'h0c3);
      end_of_test();
   end
endmodule // slice_output_delay_regs_tb_top
